//--- hw/uhpr_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module uhpr_pin_cell (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic func_sel_hi_i,
    input  wire logic func_sel_lo_i,
    input  wire logic drive_cfg_hi_i,
    input  wire logic drive_cfg_lo_i,
    input  wire logic direction_i,
    input  wire logic data_latch_i,
    input  wire logic alt_out_i,
    output logic      pad_o,
    output logic      pad_oe_o,
    output logic      routed_o
);

    logic pad_reg;
    logic pad_next;
    logic oe_reg;
    logic oe_next;
    logic routed_reg;
    logic routed_next;

    // Pick the pin value and decide when the pad is driven
    always_comb begin
        // R1: secondary function select
        routed_next = ({func_sel_hi_i, func_sel_lo_i} == uhpr_pkg::FUNC_SECONDARY);
        // R4: latch ignored when routed
        pad_next = routed_next ? alt_out_i : data_latch_i;
        oe_next  = 1'b0;
        // R3: direction zero drives
        if (direction_i == uhpr_pkg::DIR_OUTPUT) begin
            // R2: drive mode decode
            case ({drive_cfg_hi_i, drive_cfg_lo_i})
                uhpr_pkg::DRIVE_CMOS:   oe_next = 1'b1;
                uhpr_pkg::DRIVE_NCH_OD: oe_next = ~pad_next;
                uhpr_pkg::DRIVE_PCH_OD: oe_next = pad_next;
                default:                oe_next = 1'b0;
            endcase
        end
    end

    // Register pad value, enable and routing flag
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_reg    <= uhpr_pkg::LINE_IDLE;
            oe_reg     <= 1'b0;
            routed_reg <= 1'b0;
        end else begin
            pad_reg    <= pad_next;
            oe_reg     <= oe_next;
            routed_reg <= routed_next;
        end
    end

    assign pad_o    = pad_reg;
    assign pad_oe_o = oe_reg;
    assign routed_o = routed_reg;

endmodule // uhpr_pin_cell
`default_nettype wire

//--- hw/uhpr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module uhpr_sync (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic async_i,
    output logic      level_o
);

    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    // Shift the pin in; the level moves once stages two and three agree
    always_comb begin
        stage_next = {stage_reg[1:0], async_i};
        level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
    end

    // Register the chain and the accepted level
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_reg <= {3{uhpr_pkg::LINE_IDLE}};
            level_reg <= uhpr_pkg::LINE_IDLE;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule // uhpr_sync
`default_nettype wire

//--- hw/uhpr_top.sv
// Operation
// R1: Tx pin carries UART output when select 01
// R2: Tx pin drives CMOS when both config bits 1
// R3: Tx pin drives only when direction bit 0
// R4: Tx data latch ignored while UART routed
// R5: Rx pin feeds UART receiver when select 01
// R6: Rx pin undriven when direction bit 1
// R7: Software picks rx input mode freely
// R8: Port-4 data bits 3..2 do not affect UART
// R9: Software changes only the UART pin bits
// R10: Port-5 bits 2..0 ignore writes, read zero
`timescale 1ns/100ps
`default_nettype none
module uhpr_top (
    input  wire logic                          core_clk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [uhpr_pkg::ADDR_W-1:0]   paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    input  wire logic [3:0]                    pstrb_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    input  wire logic                          uart0_transmit_line_i,
    output logic                               uart0_receive_line_o,
    output logic                               tx_pin_port5_bit5_o,
    output logic                               tx_pin_port5_bit5_oe_o,
    input  wire logic                          rx_pin_port4_bit2_i,
    output logic                               rx_pin_port4_bit2_o,
    output logic                               rx_pin_port4_bit2_oe_o
);

    // Port register file and bus answer
    logic [7:0]  regs_reg  [uhpr_pkg::SLOT_COUNT];
    logic [7:0]  regs_next [uhpr_pkg::SLOT_COUNT];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        rxline_reg;
    logic        rxline_next;

    // Decoded address and pin state
    logic                        hit;
    logic [uhpr_pkg::SLOT_W-1:0] slot;
    logic                        aligned;
    logic                        is_status;
    logic                        rx_level;
    logic                        tx_routed;
    logic                        rx_routed;
    logic                        rx_route_now;
    logic [7:0]                  status_byte;

    // Map a word index onto a register slot; bit 4 flags a hit
    function automatic logic [uhpr_pkg::SLOT_W:0] slot_of(
        input logic [uhpr_pkg::IDX_W-1:0] idx
    );
        logic [uhpr_pkg::SLOT_W:0] res;
        res = '0;
        for (int i = 0; i < uhpr_pkg::SLOT_COUNT; i++) begin
            if (idx == uhpr_pkg::SLOT_INDEX[i]) begin
                res = {1'b1, i[uhpr_pkg::SLOT_W-1:0]};
            end
        end
        return res;
    endfunction

    // Address decode
    always_comb begin
        {hit, slot} = slot_of(paddr_i[uhpr_pkg::ADDR_W-1:2]);
        aligned     = (paddr_i[1:0] == 2'h0);
        is_status   = (paddr_i[uhpr_pkg::ADDR_W-1:2] == uhpr_pkg::IDX_STATUS);
    end

    // Receive pin routing, taken straight from the select registers
    always_comb begin
        // R5: receive path select
        rx_route_now = ({regs_reg[uhpr_pkg::SLOT_P4_SEL1][uhpr_pkg::RX_BIT],
                         regs_reg[uhpr_pkg::SLOT_P4_SEL0][uhpr_pkg::RX_BIT]}
                        == uhpr_pkg::FUNC_SECONDARY);
        status_byte  = 8'h00;
        status_byte[uhpr_pkg::ST_TX_ROUTED] = tx_routed;
        status_byte[uhpr_pkg::ST_RX_ROUTED] = rx_routed;
        status_byte[uhpr_pkg::ST_RX_LEVEL]  = rx_level;
        status_byte[uhpr_pkg::ST_TX_DRIVEN] = tx_pin_port5_bit5_oe_o;
    end

    // APB slave: answer prepared in setup, write applied at the access edge
    always_comb begin
        regs_next    = regs_reg;
        prdata_next  = prdata_reg;
        pslverr_next = pslverr_reg;
        pready_next  = psel_i && !penable_i;
        if (psel_i && !penable_i) begin
            prdata_next  = 32'h0000_0000;
            pslverr_next = !aligned || !(hit || is_status);
            if (aligned && hit) begin
                prdata_next = {24'h00_0000, regs_reg[slot]};
            end else if (aligned && is_status) begin
                prdata_next = {24'h00_0000, status_byte};
            end
        end
        if (psel_i && penable_i && pready_reg && pwrite_i && aligned && hit && pstrb_i[0]) begin
            // R10: unimplemented bits dropped
            regs_next[slot] = pwdata_i[7:0] & uhpr_pkg::SLOT_MASK[slot];
        end
    end

    // Register the port file and the bus answer
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < uhpr_pkg::SLOT_COUNT; i++) begin
                regs_reg[i] <= uhpr_pkg::REG_RESET;
            end
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            regs_reg    <= regs_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Transmit pin cell
    uhpr_pin_cell u_tx_cell (
        .core_clk_i     (core_clk_i),
        .arst_n_i       (arst_n_i),
        .func_sel_hi_i  (regs_reg[uhpr_pkg::SLOT_P5_SEL1][uhpr_pkg::TX_BIT]),
        .func_sel_lo_i  (regs_reg[uhpr_pkg::SLOT_P5_SEL0][uhpr_pkg::TX_BIT]),
        .drive_cfg_hi_i (regs_reg[uhpr_pkg::SLOT_P5_CFG1][uhpr_pkg::TX_BIT]),
        .drive_cfg_lo_i (regs_reg[uhpr_pkg::SLOT_P5_CFG0][uhpr_pkg::TX_BIT]),
        .direction_i    (regs_reg[uhpr_pkg::SLOT_P5_DIR][uhpr_pkg::TX_BIT]),
        .data_latch_i   (regs_reg[uhpr_pkg::SLOT_P5_DATA][uhpr_pkg::TX_BIT]),
        .alt_out_i      (uart0_transmit_line_i),
        .pad_o          (tx_pin_port5_bit5_o),
        .pad_oe_o       (tx_pin_port5_bit5_oe_o),
        .routed_o       (tx_routed)
    );

    // Receive pin cell; as a secondary input it drives only its own latch
    // R6: input direction releases pad
    uhpr_pin_cell u_rx_cell (
        .core_clk_i     (core_clk_i),
        .arst_n_i       (arst_n_i),
        .func_sel_hi_i  (regs_reg[uhpr_pkg::SLOT_P4_SEL1][uhpr_pkg::RX_BIT]),
        .func_sel_lo_i  (regs_reg[uhpr_pkg::SLOT_P4_SEL0][uhpr_pkg::RX_BIT]),
        .drive_cfg_hi_i (regs_reg[uhpr_pkg::SLOT_P4_CFG1][uhpr_pkg::RX_BIT]),
        .drive_cfg_lo_i (regs_reg[uhpr_pkg::SLOT_P4_CFG0][uhpr_pkg::RX_BIT]),
        .direction_i    (regs_reg[uhpr_pkg::SLOT_P4_DIR][uhpr_pkg::RX_BIT]),
        .data_latch_i   (regs_reg[uhpr_pkg::SLOT_P4_DATA][uhpr_pkg::RX_BIT]),
        .alt_out_i      (regs_reg[uhpr_pkg::SLOT_P4_DATA][uhpr_pkg::RX_BIT]),
        .pad_o          (rx_pin_port4_bit2_o),
        .pad_oe_o       (rx_pin_port4_bit2_oe_o),
        .routed_o       (rx_routed)
    );

    // Pin level into the core clock domain
    uhpr_sync u_rx_sync (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .async_i    (rx_pin_port4_bit2_i),
        .level_o    (rx_level)
    );

    // Receive line: pin level when routed, idle high otherwise
    always_comb begin
        // R8: data latch not in path
        rxline_next = rx_route_now ? rx_level : uhpr_pkg::LINE_IDLE;
    end

    // Register the receive line
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rxline_reg <= uhpr_pkg::LINE_IDLE;
        end else begin
            rxline_reg <= rxline_next;
        end
    end

    assign prdata_o             = prdata_reg;
    assign pready_o             = pready_reg;
    assign pslverr_o            = pslverr_reg;
    assign uart0_receive_line_o = rxline_reg;

    // Checks on the routing and the bus
    logic tx_route_cond;
    logic tx_cmos_cond;
    logic tx_dir_in;
    logic rx_dir_in;
    assign tx_route_cond = !regs_reg[uhpr_pkg::SLOT_P5_SEL1][uhpr_pkg::TX_BIT]
                         && regs_reg[uhpr_pkg::SLOT_P5_SEL0][uhpr_pkg::TX_BIT];
    assign tx_cmos_cond  = regs_reg[uhpr_pkg::SLOT_P5_CFG1][uhpr_pkg::TX_BIT]
                         && regs_reg[uhpr_pkg::SLOT_P5_CFG0][uhpr_pkg::TX_BIT];
    assign tx_dir_in     = regs_reg[uhpr_pkg::SLOT_P5_DIR][uhpr_pkg::TX_BIT];
    assign rx_dir_in     = regs_reg[uhpr_pkg::SLOT_P4_DIR][uhpr_pkg::RX_BIT];

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    // R1: UART output on tx pin
    a_tx_uart_follow: assert property ($past(tx_route_cond) |-> tx_pin_port5_bit5_o == $past(uart0_transmit_line_i)) else $error("tx pin does not follow UART output"); // R1
    // R2: CMOS drive enable
    a_tx_cmos_drive: assert property ($past(tx_cmos_cond && !tx_dir_in) |-> tx_pin_port5_bit5_oe_o) else $error("tx pin not driven in CMOS mode"); // R2
    // R3: input direction releases
    a_tx_dir_release: assert property ($past(tx_dir_in) |-> !tx_pin_port5_bit5_oe_o) else $error("tx pin driven while direction is input"); // R3
    // R4: latch ignored
    a_tx_latch_ignored: assert property (($past(tx_route_cond) && $past(tx_route_cond, 2) && ($past(uart0_transmit_line_i) == $past(uart0_transmit_line_i, 2))) |-> $stable(tx_pin_port5_bit5_o)) else $error("tx pin moved without UART change"); // R4
    // R5: receive path
    a_rx_uart_feed: assert property ($past(rx_route_now) |-> uart0_receive_line_o == $past(rx_level)) else $error("receiver not fed from rx pin"); // R5
    // R6: rx pin released
    a_rx_dir_release: assert property ($past(rx_dir_in) |-> !rx_pin_port4_bit2_oe_o) else $error("rx pin driven while direction is input"); // R6
    // R8: data bits no effect
    a_rx_latch_ignored: assert property (($past(rx_route_now) && $past(rx_route_now, 2) && ($past(rx_level) == $past(rx_level, 2))) |-> $stable(uart0_receive_line_o)) else $error("receive line moved without pin change"); // R8
    // R10: port 5 low bits zero
    a_p5_low_zero: assert property ((regs_reg[uhpr_pkg::SLOT_P5_DATA][2:0] | regs_reg[uhpr_pkg::SLOT_P5_DIR][2:0] | regs_reg[uhpr_pkg::SLOT_P5_CFG0][2:0] | regs_reg[uhpr_pkg::SLOT_P5_CFG1][2:0] | regs_reg[uhpr_pkg::SLOT_P5_SEL0][2:0] | regs_reg[uhpr_pkg::SLOT_P5_SEL1][2:0]) == 3'h0) else $error("port 5 unimplemented bits set"); // R10
    a_apb_ready_next: assert property ((psel_i && !penable_i) |=> pready_o) else $error("pready missing in access phase");

    c_tx_routed_cmos: cover property (tx_route_cond && tx_cmos_cond && !tx_dir_in ##1 tx_pin_port5_bit5_oe_o);
    c_rx_routed_in: cover property (rx_route_now && rx_dir_in ##2 !uart0_receive_line_o);
    c_apb_write: cover property (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o);
    c_apb_error: cover property (psel_i && penable_i && pready_o && pslverr_o);

endmodule // uhpr_top
`default_nettype wire

//--- include/uhpr_pkg.sv
`default_nettype none
package uhpr_pkg;

    // APB geometry: a printed offset is a word index, byte address is four times it
    localparam int          ADDR_W      = 20;
    localparam int          IDX_W       = 18;
    localparam int          SLOT_COUNT  = 12;
    localparam int          SLOT_W      = 4;

    // Word indices of the port registers, in slot order
    localparam logic [IDX_W-1:0] IDX_P4_DATA = 18'h0F244;
    localparam logic [IDX_W-1:0] IDX_P4_DIR  = 18'h0F245;
    localparam logic [IDX_W-1:0] IDX_P4_CFG0 = 18'h0F246;
    localparam logic [IDX_W-1:0] IDX_P4_CFG1 = 18'h0F247;
    localparam logic [IDX_W-1:0] IDX_P4_SEL0 = 18'h0F248;
    localparam logic [IDX_W-1:0] IDX_P4_SEL1 = 18'h0F249;
    localparam logic [IDX_W-1:0] IDX_P5_DATA = 18'h0F252;
    localparam logic [IDX_W-1:0] IDX_P5_DIR  = 18'h0F253;
    localparam logic [IDX_W-1:0] IDX_P5_CFG0 = 18'h0F254;
    localparam logic [IDX_W-1:0] IDX_P5_CFG1 = 18'h0F255;
    localparam logic [IDX_W-1:0] IDX_P5_SEL0 = 18'h0F256;
    localparam logic [IDX_W-1:0] IDX_P5_SEL1 = 18'h0F257;
    localparam logic [IDX_W-1:0] IDX_STATUS  = 18'h0F25A;

    localparam logic [IDX_W-1:0] SLOT_INDEX [SLOT_COUNT] = '{
        IDX_P4_DATA, IDX_P4_DIR, IDX_P4_CFG0, IDX_P4_CFG1, IDX_P4_SEL0, IDX_P4_SEL1,
        IDX_P5_DATA, IDX_P5_DIR, IDX_P5_CFG0, IDX_P5_CFG1, IDX_P5_SEL0, IDX_P5_SEL1
    };

    // Slot numbers inside the register array
    localparam logic [SLOT_W-1:0] SLOT_P4_DATA = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_P4_DIR  = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_P4_CFG0 = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_P4_CFG1 = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_P4_SEL0 = 4'h4;
    localparam logic [SLOT_W-1:0] SLOT_P4_SEL1 = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_P5_DATA = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_P5_DIR  = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_P5_CFG0 = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_P5_CFG1 = 4'h9;
    localparam logic [SLOT_W-1:0] SLOT_P5_SEL0 = 4'hA;
    localparam logic [SLOT_W-1:0] SLOT_P5_SEL1 = 4'hB;

    // Implemented bits per register; port 5 has no bits 2 to 0
    localparam logic [7:0] PORT4_MASK = 8'hFF;
    localparam logic [7:0] PORT5_MASK = 8'hF8;
    localparam logic [7:0] SLOT_MASK [SLOT_COUNT] = '{
        PORT4_MASK, PORT4_MASK, PORT4_MASK, PORT4_MASK, PORT4_MASK, PORT4_MASK,
        PORT5_MASK, PORT5_MASK, PORT5_MASK, PORT5_MASK, PORT5_MASK, PORT5_MASK
    };
    localparam logic [7:0] REG_RESET = 8'h00;

    // Pin positions
    localparam int TX_BIT = 5;
    localparam int RX_BIT = 2;

    // Function select {hi,lo} and output drive {hi,lo} codes
    localparam logic [1:0] FUNC_SECONDARY = 2'h1;
    localparam logic [1:0] DRIVE_HIZ      = 2'h0;
    localparam logic [1:0] DRIVE_PCH_OD   = 2'h1;
    localparam logic [1:0] DRIVE_NCH_OD   = 2'h2;
    localparam logic [1:0] DRIVE_CMOS     = 2'h3;
    localparam logic       DIR_OUTPUT     = 1'b0;
    localparam logic       DIR_INPUT      = 1'b1;

    // Status register bit positions
    localparam int ST_TX_ROUTED = 0;
    localparam int ST_RX_ROUTED = 1;
    localparam int ST_RX_LEVEL  = 2;
    localparam int ST_TX_DRIVEN = 3;

    // Idle level of a UART line
    localparam logic LINE_IDLE = 1'b1;

endpackage : uhpr_pkg
`default_nettype wire

//--- tb/uart0_half_duplex_pin_routing_test.sv
`timescale 1ns/100ps
`default_nettype none
module uart0_half_duplex_pin_routing_test;
    logic        core_clk_i = 1'b0;
    logic        arst_n_i   = 1'b0;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [19:0] paddr_i    = 20'h00000;
    logic [31:0] pwdata_i   = 32'h00000000;
    logic [3:0]  pstrb_i    = 4'h0;
    logic        tx_in      = 1'b1;
    logic        level      = 1'b1;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, recv_o, tx_pad, tx_oe, rx_pad, rx_oe;
    logic        tx_wire, rx_wire;
    logic [31:0] rd;
    logic        err, v, rxb;
    logic [7:0]  d;
    int          fail_count = 0;
    int          num_checks = 0;

    // 250 MHz core clock
    always #2 core_clk_i = ~core_clk_i;

    uhpr_top dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .uart0_transmit_line_i(tx_in), .uart0_receive_line_o(recv_o),
        .tx_pin_port5_bit5_o(tx_pad), .tx_pin_port5_bit5_oe_o(tx_oe),
        .rx_pin_port4_bit2_i(rx_wire), .rx_pin_port4_bit2_o(rx_pad),
        .rx_pin_port4_bit2_oe_o(rx_oe));

    uhpr_far_end far (.core_clk_i(core_clk_i), .tx_pad_i(tx_pad), .tx_oe_i(tx_oe),
        .rx_pad_i(rx_pad), .rx_oe_i(rx_oe), .line_level_i(level), .tx_wire_o(tx_wire),
        .rx_wire_o(rx_wire));

    // Counts, verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; pready and the answer are taken at the rising edge
    task automatic apb(input logic wr, input logic [17:0] idx, input logic [7:0] wd,
                       input logic [3:0] strb);
        int n;
        @(posedge core_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= {idx, 2'b00};
        pwdata_i  <= {24'($urandom()), wd};
        pstrb_i   <= strb;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Read-modify-write of one bit, other bits left as they were
    task automatic set_bit(input logic [17:0] idx, input int b, input logic val);
        logic [7:0] nv;
        apb(1'b0, idx, 8'h00, 4'hF);
        nv    = rd[7:0];
        nv[b] = val;
        apb(1'b1, idx, nv, 4'hF);
        apb(1'b0, idx, 8'h00, 4'hF);
        check("rmw", rd, {24'h000000, nv});
    endtask

    // Drive the UART output for one cycle, then look at the pad
    task automatic tx_step(input logic val, input logic exp_pad, input logic exp_oe);
        @(posedge core_clk_i);
        tx_in <= val;
        @(posedge core_clk_i);
        #1;
        check("tx_pad", tx_pad, exp_pad);
        check("tx_oe", tx_oe, exp_oe);
    endtask

    // Bounded wait for the receive line to settle
    task automatic wait_recv(input logic exp);
        int n;
        for (n = 0; n < 12 && recv_o !== exp; n++) begin
            @(negedge core_clk_i);
        end
        check("recv", recv_o, exp);
        if (recv_o !== exp) begin
            end_of_test();
        end
    endtask

    initial begin
        void'($urandom(17));
        repeat (2) @(posedge core_clk_i);
        #1;
        check("in_reset", {pready_o, tx_pad, rx_pad, tx_oe, rx_oe, recv_o}, 32'h00000019);
        @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < uhpr_pkg::SLOT_COUNT; i++) begin
            apb(1'b0, uhpr_pkg::SLOT_INDEX[i], 8'h00, 4'hF);
            check("reset_val", rd, {24'h000000, uhpr_pkg::REG_RESET});
        end
        $display("test reset values done");
        for (int k = 0; k < 24; k++) begin
            d = 8'($urandom());
            apb(1'b1, uhpr_pkg::SLOT_INDEX[k%12], d, 4'hF);
            apb(1'b0, uhpr_pkg::SLOT_INDEX[k%12], 8'h00, 4'hF);
            check("rw", rd, {24'h000000, d & uhpr_pkg::SLOT_MASK[k%12]});
        end
        // Known contents first, then a write with no strobe must leave them
        apb(1'b1, uhpr_pkg::IDX_P4_DATA, d, 4'hF);
        apb(1'b1, uhpr_pkg::IDX_P4_DATA, ~d, 4'h0);
        apb(1'b0, uhpr_pkg::IDX_P4_DATA, 8'h00, 4'hF);
        check("strb_off", rd[7:0], 32'h00000000 | (d & 8'hFF));
        apb(1'b1, 18'h0F250, 8'hFF, 4'hF);
        check("unmapped_err", err, 32'h00000001);
        apb(1'b0, 18'h0F250, 8'h00, 4'hF);
        check("unmapped_rd", {rd[30:0], err}, 32'h00000001);
        $display("test register access done");
        set_bit(uhpr_pkg::IDX_P5_SEL1, 5, 1'b0);
        set_bit(uhpr_pkg::IDX_P5_SEL0, 5, 1'b1);
        set_bit(uhpr_pkg::IDX_P5_CFG1, 5, 1'b1);
        set_bit(uhpr_pkg::IDX_P5_CFG0, 5, 1'b1);
        set_bit(uhpr_pkg::IDX_P5_DIR, 5, uhpr_pkg::DIR_OUTPUT);
        for (int k = 0; k < 4; k++) begin
            set_bit(uhpr_pkg::IDX_P5_DATA, 5, k[0]);
            for (int j = 0; j < 8; j++) begin
                v = 1'($urandom());
                tx_step(v, v, 1'b1);
                check("tx_wire", tx_wire, v);
            end
        end
        $display("test tx routing done");
        set_bit(uhpr_pkg::IDX_P5_SEL1, 5, 1'b1);
        for (int k = 0; k < 2; k++) begin
            set_bit(uhpr_pkg::IDX_P5_DATA, 5, k[0]);
            tx_step(~k[0], k[0], 1'b1);
        end
        set_bit(uhpr_pkg::IDX_P5_SEL1, 5, 1'b0);
        set_bit(uhpr_pkg::IDX_P5_DIR, 5, uhpr_pkg::DIR_INPUT);
        // Input direction: pad value still follows the UART but is not driven
        tx_step(1'b0, 1'b0, 1'b0);
        $display("test tx select and direction done");
        set_bit(uhpr_pkg::IDX_P4_SEL1, 2, 1'b0);
        set_bit(uhpr_pkg::IDX_P4_SEL0, 2, 1'b1);
        set_bit(uhpr_pkg::IDX_P4_DIR, 2, uhpr_pkg::DIR_INPUT);
        for (int k = 0; k < 6; k++) begin
            // Any input mode chosen by software
            set_bit(uhpr_pkg::IDX_P4_CFG0, 2, k[0]);
            set_bit(uhpr_pkg::IDX_P4_CFG1, 2, k[1]);
            v   = 1'($urandom());
            rxb = k[0] ? rxb : v;
            set_bit(uhpr_pkg::IDX_P4_DATA, 2 + k[0], v);
            @(posedge core_clk_i);
            level <= k[0] ^ k[2] ^ 1'($urandom());
            repeat (2) @(posedge core_clk_i);
            check("rx_oe", rx_oe, 1'b0);
            check("rx_pad", rx_pad, rxb);
            wait_recv(level);
        end
        // Status: tx routed, rx routed, synced level, tx released
        apb(1'b0, uhpr_pkg::IDX_STATUS, 8'h00, 4'hF);
        check("status", rd, {28'h0000000, 1'b0, level, 2'h3});
        set_bit(uhpr_pkg::IDX_P4_SEL0, 2, 1'b0);
        @(posedge core_clk_i);
        level <= 1'b0;
        // Unrouted receiver idles high
        wait_recv(uhpr_pkg::LINE_IDLE);
        $display("test rx routing done");
        end_of_test();
    end
endmodule // uart0_half_duplex_pin_routing_test
`default_nettype wire

//--- tb/uhpr_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module uhpr_far_end (
    input  wire logic core_clk_i,
    input  wire logic tx_pad_i,
    input  wire logic tx_oe_i,
    input  wire logic rx_pad_i,
    input  wire logic rx_oe_i,
    input  wire logic line_level_i,
    output logic      tx_wire_o,
    output logic      rx_wire_o
);
    logic last_tx_reg = 1'b0;

    // Last driven level, so a released line never shows a stale value
    always_ff @(posedge core_clk_i) begin
        if (tx_oe_i) begin
            last_tx_reg <= tx_pad_i;
        end
    end

    // Released transmit wire shows the inverse; device wins the receive wire
    assign tx_wire_o = tx_oe_i ? tx_pad_i : ~last_tx_reg;
    assign rx_wire_o = rx_oe_i ? rx_pad_i : line_level_i;
endmodule // uhpr_far_end
`default_nettype wire
